//--- src/host_port_regs.svh
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
// Notes on behaviour
// - mode pins: 001 selects 6800, 011 8080, 000 four-wire serial, 010 two-wire.
// - eight-bit bidirectional parallel data bus in both parallel modes.
// - 8080 mode: read strobe active low; bus driven only while it is low.
// - 6800 mode: read-strobe pin is an active-high enable clock.
// - serial modes: data pin 0 is clock, pin 1 data in, pins 2-7 undriven.
// - two-wire mode: pin 0 clock, pin 1 bidirectional data, pins 2-7 undriven; this port never drives pin 1, data_oe stays zero.
// - 6800 mode: read/write high reads RAM or status, chosen by data/command.
// - 6800 mode: read/write low writes; data/command picks RAM or command.
// - 6800 mode: enable latches only while chip select is low.
// - 8080 mode: read strobe low with select reads; data/command high selects RAM.
// - 8080 mode: write strobe low with select writes RAM or command.
// - display-data reads are pipelined; the first read after setup is a dummy.
// - data/command high means display data, low means command register.
// - 8080 mode: write data captured at rising edge of write strobe.
// - chip select high: strobes ignored, data pins undriven; an access opened while selected still closes after select rises.

// interface-select patterns {bit0,bit1,bit2}
`define IF_SEL_6800      3'b001
`define IF_SEL_8080      3'b011
`define IF_SEL_SPI4      3'b000
`define IF_SEL_TWOWIRE   3'b010
`define IF_SEL_SPI3      3'b100
// widths and reset values
`define DATA_W           8
`define SYNC_STAGES      2
`define RD_PIPE_RESET    8'h00
`endif

//--- src/host_port_pkg.sv
package host_port_pkg;
  // decoded bus mode
  typedef enum logic [4:0] {
    MODE_6800    = 5'b00001,
    MODE_8080    = 5'b00010,
    MODE_SPI4    = 5'b00100,
    MODE_SPI3    = 5'b01000,
    MODE_TWOWIRE = 5'b10000
  } mode_type;
  // synchronised view of the host strobes
  typedef struct packed {
    logic cs_n;
    logic dc;
    logic rd;
    logic wr;
  } strobe_type;
  // one internal transfer event
  typedef struct packed {
    logic       valid;
    logic       is_data;
    logic [7:0] value;
  } xfer_type;
endpackage

//--- src/strobe_sync.sv
`timescale 1ns/100ps
`include "host_port_regs.svh"
// two-stage synchroniser for a bundle of host lines
module strobe_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // lines
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage1_nxt;
  logic [WIDTH-1:0] stage2_nxt;

  // first stage is read only by the second
  always_comb
  begin
    stage1_nxt = async_in;
    stage2_nxt = stage1_r;
  end

  // idle value is all ones: select and 8080 strobes inactive, 6800 enable high but gated by select
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_r <= '1;
      stage2_r <= '1;
    end
    else
    begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign sync_out = stage2_r;
endmodule

//--- src/read_pipe.sv
`timescale 1ns/100ps
`include "host_port_regs.svh"
// one-deep display-data read pipeline: each read returns the previous fetch
module read_pipe (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // read event and fetched RAM word
  input  wire logic       rd_event,
  input  wire logic [7:0] ram_rdata,
  // byte presented to the host
  output logic      [7:0] out_data,
  output logic            primed
);
  logic [7:0] latch_r;
  logic [7:0] latch_nxt;
  logic       primed_r;
  logic       primed_nxt;

  // on each read the latch takes the word fetched now; host sees it next read
  always_comb
  begin
    latch_nxt  = latch_r;
    primed_nxt = primed_r;
    if (rd_event)
    begin
      latch_nxt  = ram_rdata;
      primed_nxt = 1'b1;
    end
  end

  // reset empties the pipeline so the next read is a dummy again
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      latch_r  <= `RD_PIPE_RESET;
      primed_r <= 1'b0;
    end
    else
    begin
      latch_r  <= latch_nxt;
      primed_r <= primed_nxt;
    end
  end

  assign out_data = latch_r;
  assign primed   = primed_r;
endmodule

//--- src/host_port.sv
`timescale 1ns/100ps
`include "host_port_regs.svh"
// ****************************************************************
// parallel host bus port
// ****************************************************************
module host_port (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // mode pins
  input  wire logic       if_sel_bit0,
  input  wire logic       if_sel_bit1,
  input  wire logic       if_sel_bit2,
  // host control pins
  input  wire logic       cs_n,
  input  wire logic       data_cmd_sel,
  input  wire logic       rd_e,
  input  wire logic       wr_rw,
  // data pins as three signals
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic      [7:0] data_oe,
  // display RAM side
  output logic            ram_wr,
  output logic            ram_rd,
  output logic      [7:0] ram_wdata,
  input  wire logic [7:0] ram_rdata,
  // command register side
  output logic            cmd_wr,
  output logic      [7:0] cmd_wdata,
  // status byte from the core
  input  wire logic [7:0] status_in,
  // serial lines handed to the serial engines
  output logic            serial_clk,
  output logic            serial_din,
  output logic            serial_mode,
  output logic            twowire_mode,
  output logic            mode_is_6800,
  output logic            mode_is_8080
);
  // ****************************************************************
  // mode decode
  // ****************************************************************
  host_port_pkg::mode_type mode;
  logic [2:0]              sel_bits;

  // pins are static straps, so a plain decode is enough
  // unused patterns fall back to four-wire serial, which never drives the bus
  assign sel_bits = {if_sel_bit0, if_sel_bit1, if_sel_bit2};
  always_comb
  begin
    case (sel_bits)
      `IF_SEL_6800:    mode = host_port_pkg::MODE_6800;
      `IF_SEL_8080:    mode = host_port_pkg::MODE_8080;
      `IF_SEL_TWOWIRE: mode = host_port_pkg::MODE_TWOWIRE;
      `IF_SEL_SPI3:    mode = host_port_pkg::MODE_SPI3;
      default:         mode = host_port_pkg::MODE_SPI4;
    endcase
  end

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic [11:0]               sync_bus;
  host_port_pkg::strobe_type strobe;
  logic [7:0]                data_sync;

  strobe_sync #(
    .WIDTH (12)
  ) u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in ({cs_n, data_cmd_sel, rd_e, wr_rw, data_in}),
    .sync_out (sync_bus)
  );
  // every bus pin (select, data/command, both strobes, data) passes the same two flops, so a byte stays
  // aligned with its strobe; split the bundle back into strobes and data
  assign strobe    = host_port_pkg::strobe_type'(sync_bus[11:8]);
  assign data_sync = sync_bus[7:0];

  // ****************************************************************
  // access decode and edge detection
  // ****************************************************************
  logic       is6800;
  logic       is8080;
  logic       access_r;
  logic       access_nxt;
  logic       prev_rd_r;
  logic       prev_rd_nxt;
  logic       prev_wr_r;
  logic       prev_wr_nxt;
  logic       prev_e_r;
  logic       prev_e_nxt;
  logic       wr_done;
  logic       rd_done;
  logic       rd_start;
  logic       dc_r;
  logic       dc_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;

  // the two parallel modes gate every event below
  assign is6800 = (mode == host_port_pkg::MODE_6800);
  assign is8080 = (mode == host_port_pkg::MODE_8080);

  // strobes only open an access while selected; in 6800 mode the enable is gated too.
  // 8080 write: byte and data/command follow the pins while the strobe is low
  // with select, and the event fires once the synchronised strobe has risen.
  // 6800: the same capture runs while the gated enable is high; the falling
  // enable commits a write or closes a read, as read/write decides.
  // a strobe phase under one clock can fall between samples and be lost:
  // nothing here stretches a pulse, so the host must keep to that spacing
  always_comb
  begin
    prev_rd_nxt = strobe.rd;
    prev_wr_nxt = strobe.wr;
    prev_e_nxt  = strobe.rd & ~strobe.cs_n;
    access_nxt  = access_r;
    dc_nxt      = dc_r;
    wdata_nxt   = wdata_r;
    wr_done     = 1'b0;
    rd_done     = 1'b0;
    rd_start    = 1'b0;
    if (is8080)
    begin
      // capture while low with select, commit at the rising edge
      if (!strobe.wr && !strobe.cs_n)
      begin
        wdata_nxt  = data_sync;
        dc_nxt     = strobe.dc;
        access_nxt = 1'b1;
      end
      if (strobe.wr && !prev_wr_r && access_r)
      begin
        wr_done    = 1'b1;
        access_nxt = 1'b0;
      end
      if (!strobe.rd && prev_rd_r && !strobe.cs_n)
      begin
        rd_start = 1'b1;
        dc_nxt   = strobe.dc;
      end
      if (strobe.rd && !prev_rd_r)
        rd_done = 1'b1;
    end
    else if (is6800)
    begin
      // enable high with select latches; falling enable ends the access
      if (prev_e_nxt)
      begin
        wdata_nxt  = data_sync;
        dc_nxt     = strobe.dc;
        access_nxt = 1'b1;
        if (!prev_e_r && strobe.wr)
          rd_start = 1'b1;
      end
      else if (prev_e_r && access_r)
      begin
        access_nxt = 1'b0;
        if (!strobe.wr)
          wr_done = 1'b1;
        else
          rd_done = 1'b1;
      end
    end
  end

  // single event per completed strobe pulse
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      access_r  <= 1'b0;
      prev_rd_r <= 1'b1;
      prev_wr_r <= 1'b1;
      prev_e_r  <= 1'b0;
      dc_r      <= 1'b0;
      wdata_r   <= 8'h00;
    end
    else
    begin
      access_r  <= access_nxt;
      prev_rd_r <= prev_rd_nxt;
      prev_wr_r <= prev_wr_nxt;
      prev_e_r  <= prev_e_nxt;
      dc_r      <= dc_nxt;
      wdata_r   <= wdata_nxt;
    end
  end

  // ****************************************************************
  // write and read events
  // ****************************************************************
  logic       ram_wr_r;
  logic       ram_wr_nxt;
  logic       cmd_wr_r;
  logic       cmd_wr_nxt;
  logic       ram_rd_r;
  logic       ram_rd_nxt;
  logic       reading_r;
  logic       reading_nxt;
  logic [7:0] out_r;
  logic [7:0] out_nxt;
  logic [7:0] pipe_data;

  // a data read returns the word fetched on the previous read
  // primed is left open: keeping count of dummy reads is the host's job
  read_pipe u_pipe (
    .clock     (clock),
    .resetn    (resetn),
    .rd_event  (rd_start & strobe.dc),
    .ram_rdata (ram_rdata),
    .out_data  (pipe_data),
    .primed    ()
  );

  // route each event by data/command; the RAM word is taken at read start,
  // on the edge that raises ram_rd, so the core must present it before the request
  always_comb
  begin
    ram_wr_nxt  = wr_done & dc_r;
    cmd_wr_nxt  = wr_done & ~dc_r;
    // status reads fetch nothing and leave the pipeline as it was
    ram_rd_nxt  = rd_start & strobe.dc;
    reading_nxt = reading_r;
    out_nxt     = out_r;
    if (rd_start)
    begin
      reading_nxt = 1'b1;
      // status is live; display data comes from the pipeline
      out_nxt     = strobe.dc ? pipe_data : status_in;
    end
    else if (rd_done)
      reading_nxt = 1'b0;
  end

  // pulses are registered so the core sees clean one-cycle strobes
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ram_wr_r  <= 1'b0;
      cmd_wr_r  <= 1'b0;
      ram_rd_r  <= 1'b0;
      reading_r <= 1'b0;
      out_r     <= 8'h00;
    end
    else
    begin
      ram_wr_r  <= ram_wr_nxt;
      cmd_wr_r  <= cmd_wr_nxt;
      ram_rd_r  <= ram_rd_nxt;
      reading_r <= reading_nxt;
      out_r     <= out_nxt;
    end
  end

  // both write targets share one byte register; only the pulses differ
  assign ram_wr    = ram_wr_r;
  assign cmd_wr    = cmd_wr_r;
  assign ram_rd    = ram_rd_r;
  assign ram_wdata = wdata_r;
  assign cmd_wdata = wdata_r;

  // ****************************************************************
  // pin drive
  // ****************************************************************
  logic drive;

  // raw pins used for the enable so the bus releases without sync lag;
  // serial modes never drive, leaving pins 2-7 high impedance.
  // the bus only turns round once a read has been decoded, a few clocks in,
  // and drops as soon as the host lifts the strobe or the select;
  // a 6800 write never turns the bus round, as read/write must be high
  always_comb
  begin
    drive = 1'b0;
    if (!cs_n && reading_r)
    begin
      if (is8080)
        drive = ~rd_e;
      else if (is6800)
        drive = rd_e & wr_rw;
    end
  end

  // one enable per pad, all equal, so the pad ring sees a uniform bus
  for (genvar b = 0; b < 8; b++)
  begin : g_pad_oe
    assign data_oe[b] = drive;
  end
  assign data_out = out_r;

  // serial lines go to the serial engines outside this block
  // the mode flags are levels the core uses to steer those engines
  assign serial_clk   = data_in[0];
  assign serial_din   = data_in[1];
  assign serial_mode  = (mode == host_port_pkg::MODE_SPI4) | (mode == host_port_pkg::MODE_SPI3);
  assign twowire_mode = (mode == host_port_pkg::MODE_TWOWIRE);
  assign mode_is_6800 = is6800;
  assign mode_is_8080 = is8080;
endmodule

//--- bench/host_port_props.sv
`timescale 1ns/100ps
// ****************************************
// host port checks
// ****************************************
module host_port_props (
  // clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // pins
  input wire logic       if_sel_bit0,
  input wire logic       if_sel_bit1,
  input wire logic       if_sel_bit2,
  input wire logic       cs_n,
  input wire logic       rd_e,
  input wire logic       wr_rw,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_oe,
  // core side
  input wire logic       ram_wr,
  input wire logic       ram_rd,
  input wire logic       cmd_wr,
  input wire logic       serial_clk,
  input wire logic       serial_din,
  input wire logic       serial_mode,
  input wire logic       twowire_mode,
  input wire logic       mode_is_6800,
  input wire logic       mode_is_8080
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // drive only for a selected read in a parallel mode
  a_oe_needs_cs: assert property (data_oe != 8'h00 |-> !cs_n) else $error("drive without select");
  a_oe_rd_low: assert property (mode_is_8080 && data_oe != 8'h00 |-> !rd_e) else $error("drive, strobe high");
  a_oe_e_high: assert property (mode_is_6800 && data_oe != 8'h00 |-> rd_e && wr_rw) else $error("drive, no E");
  a_serial_quiet: assert property (serial_mode || twowire_mode |-> data_oe == 8'h00 && !ram_wr && !cmd_wr
    && !ram_rd) else $error("serial mode active");
  a_serial_pass: assert property (serial_mode || twowire_mode |-> {serial_din, serial_clk} == data_in[1:0])
    else $error("serial lines wrong");
  a_mode_8080: assert property (mode_is_8080 == ({if_sel_bit0, if_sel_bit1, if_sel_bit2} == 3'b011))
    else $error("8080 decode");
  a_mode_6800: assert property (mode_is_6800 == ({if_sel_bit0, if_sel_bit1, if_sel_bit2} == 3'b001))
    else $error("6800 decode");
  // one event per strobe: pulses last a single cycle
  a_wr_single: assert property (ram_wr |=> !ram_wr) else $error("ram write too long");
  a_cmd_single: assert property ($rose(cmd_wr) |=> $fell(cmd_wr)) else $error("cmd write too long");
  a_rd_single: assert property (ram_rd |=> !ram_rd) else $error("ram read too long");
  a_dc_exclusive: assert property (not (ram_wr && cmd_wr)) else $error("both writes");
  c_ram_wr: cover property (ram_wr);
  c_cmd_wr: cover property (cmd_wr);
  c_ram_rd: cover property (ram_rd);
endmodule
bind host_port host_port_props i_props (.clock(clock), .resetn(resetn), .if_sel_bit0(if_sel_bit0),
  .if_sel_bit1(if_sel_bit1), .if_sel_bit2(if_sel_bit2), .cs_n(cs_n), .rd_e(rd_e), .wr_rw(wr_rw),
  .data_in(data_in), .data_oe(data_oe), .ram_wr(ram_wr), .ram_rd(ram_rd), .cmd_wr(cmd_wr),
  .serial_clk(serial_clk), .serial_din(serial_din), .serial_mode(serial_mode),
  .twowire_mode(twowire_mode), .mode_is_6800(mode_is_6800), .mode_is_8080(mode_is_8080));

//--- bench/host_model.sv
`timescale 1ns/100ps
// ****************************************
// host cpu bus model
// ****************************************
module host_model (
  // clock and bus level
  input  wire logic       clock,
  input  wire logic [7:0] bus,
  // strobes and data drive
  output logic            cs_n,
  output logic            dc,
  output logic            rd_e,
  output logic            wr_rw,
  output logic      [7:0] hd,
  output logic            hoe
);
  // idle: 8080 strobes high, 6800 enable low
  task automatic idle(input bit m68);
    cs_n = 1'b1;
    rd_e = !m68;
    wr_rw = 1'b1;
    hoe = 1'b0;
  endtask
  // one byte; strobe held 8 cycles, well past the synchroniser
  task automatic xfer(input bit m68, input bit sel, input bit d_c, input bit rd,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clock) #1;
    cs_n = !sel;
    dc = d_c;
    hd = d;
    hoe = !rd;
    if (m68)
      wr_rw = rd;
    @(posedge clock) #1;
    if (m68)
      rd_e = 1'b1;
    else if (rd)
      rd_e = 1'b0;
    else
      wr_rw = 1'b0;
    repeat (8) @(posedge clock);
    q = bus;
    #1;
    rd_e = !m68;
    wr_rw = m68 ? rd : 1'b1;
    // data and select kept past the closing edge
    repeat (2) @(posedge clock);
    #1;
    idle(m68);
    repeat (4) @(posedge clock);
  endtask
  // quiet bus at time zero, fixed straps assumed
  initial
  begin
    dc = 1'b0;
    hd = 8'h00;
    idle(1'b0);
  end
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
`include "host_port_regs.svh"
// ****************************************
// host port testbench
// ****************************************
module tb;
  logic       clock, resetn, cs_n, dc, rd_e, wr_rw, hoe, ram_wr, ram_rd, cmd_wr;
  logic       sclk, sdin, smode, tmode, m68, m80;
  logic [2:0] ms;
  logic [7:0] hd, bus, dout, doe, wdat, cwdat, rdat, stat, q, last_w;
  int         fails, n_checks, n_ram, n_cmd, n_rd;
  // released host lines show the inverse of their last value
  assign bus = (dout & doe) | ((hoe ? hd : ~hd) & ~doe);
  host_port i_dut (.clock(clock), .resetn(resetn), .if_sel_bit0(ms[2]), .if_sel_bit1(ms[1]),
    .if_sel_bit2(ms[0]), .cs_n(cs_n), .data_cmd_sel(dc), .rd_e(rd_e), .wr_rw(wr_rw), .data_in(bus),
    .data_out(dout), .data_oe(doe), .ram_wr(ram_wr), .ram_rd(ram_rd), .ram_wdata(wdat),
    .ram_rdata(rdat), .cmd_wr(cmd_wr), .cmd_wdata(cwdat), .status_in(stat), .serial_clk(sclk),
    .serial_din(sdin), .serial_mode(smode), .twowire_mode(tmode), .mode_is_6800(m68),
    .mode_is_8080(m80));
  host_model i_host (.clock(clock), .bus(bus), .cs_n(cs_n), .dc(dc), .rd_e(rd_e),
    .wr_rw(wr_rw), .hd(hd), .hoe(hoe));
  // clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // count write events and keep the last byte
  always @(posedge clock)
  begin
    if (ram_wr === 1'b1)
    begin
      n_ram++;
      last_w = wdat;
    end
    if (cmd_wr === 1'b1)
    begin
      n_cmd++;
      last_w = cwdat;
    end
    if (ram_rd === 1'b1)
      n_rd++;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // reset also clears the event counters
  task automatic do_reset(input logic [2:0] m);
    @(posedge clock) #1;
    resetn = 1'b0;
    ms = m;
    i_host.idle(m == `IF_SEL_6800);
    repeat (8) @(posedge clock);
    #1 resetn = 1'b1;
    n_ram = 0;
    n_cmd = 0;
    n_rd = 0;
    repeat (2) @(posedge clock);
  endtask
  task automatic t_8080_wr;
    do_reset(`IF_SEL_8080);
    chk(m80, 1'b1, "8080 mode");
    i_host.xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'ha5, q);
    chk(n_ram, 1, "ram write");
    chk(last_w, 8'ha5, "ram byte");
    i_host.xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h3c, q);
    chk(n_cmd, 1, "cmd write");
    chk(last_w, 8'h3c, "cmd byte");
    i_host.xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h11, q);
    i_host.xfer(1'b0, 1'b0, 1'b1, 1'b1, 8'h11, q);
    chk(n_ram, 1, "write without select");
    chk(q, 8'hee, "drive without select");
  endtask
  task automatic t_8080_rd;
    rdat = 8'h5a;
    i_host.xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h00, "dummy read");
    rdat = 8'h77;
    i_host.xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h5a, "data read");
    rdat = 8'h3e;
    stat = 8'hc3;
    i_host.xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, q);
    chk(q, 8'hc3, "status read");
    i_host.xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h77, "pipe after status");
    chk(n_rd, 3, "ram fetches");
    do_reset(`IF_SEL_8080);
    i_host.xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h00, "dummy after reset");
  endtask
  task automatic t_6800;
    do_reset(`IF_SEL_6800);
    chk(m68, 1'b1, "6800 mode");
    rdat = 8'h5a;
    i_host.xfer(1'b1, 1'b1, 1'b1, 1'b0, 8'h96, q);
    chk(last_w, 8'h96, "6800 ram byte");
    i_host.xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h69, q);
    chk(n_cmd, 1, "6800 cmd write");
    i_host.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h11, q);
    chk(n_ram, 1, "E without select");
    i_host.xfer(1'b1, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h00, "6800 dummy");
    i_host.xfer(1'b1, 1'b1, 1'b1, 1'b1, 8'h00, q);
    chk(q, 8'h5a, "6800 read");
    chk(n_rd, 2, "6800 fetches");
  endtask
  // serial straps: no parallel events, pins 0 and 1 handed on
  task automatic t_serial;
    logic [2:0] tbl [3];
    tbl = '{`IF_SEL_SPI4, `IF_SEL_SPI3, `IF_SEL_TWOWIRE};
    foreach (tbl[i])
    begin
      do_reset(tbl[i]);
      i_host.xfer(1'b0, 1'b1, tbl[i] != `IF_SEL_SPI3, 1'b0, 8'h02, q);
      chk(n_ram + n_cmd + n_rd, 0, "serial event");
      chk(doe, 8'h00, "serial drive");
      chk({sclk, sdin}, 2'b10, "serial lines");
      chk(tmode, tbl[i] == `IF_SEL_TWOWIRE, "two-wire flag");
      chk(smode, tbl[i] != `IF_SEL_TWOWIRE, "serial flag");
      chk(m80 | m68, 1'b0, "parallel flag");
    end
  endtask
  // main sequence
  initial
  begin
    fails = 0;
    n_checks = 0;
    resetn = 1'b0;
    ms = `IF_SEL_8080;
    rdat = 8'h00;
    stat = 8'h00;
    repeat (8) @(posedge clock);
    t_8080_wr;
    t_8080_rd;
    t_6800;
    t_serial;
    finish_test;
  end
  // hang guard, about ten times the expected run
  initial
  begin
    #20000;
    fails++;
    finish_test;
  end
endmodule
